// ==== pkg/rll_consts.vh ====
// What this block does
// RULE1: Local state accepts panel keys and executes commands
// RULE2: Lockout command enters a lockout state at any time
// RULE3: Remote command moves local to remote
// RULE4: Remote command moves local-lockout to remote-lockout
// RULE5: Remote ignores panel keys except power, go-local
// RULE6: Go-local key or local command returns remote to local
// RULE7: Remote-lockout ignores all panel keys except power
// RULE8: Local command moves remote-lockout to local-lockout
// RULE9: Selecting network port starts listening on configured port
// RULE10: Connected session refuses every further connection attempt
// RULE11: Deselecting network port closes the client session
// RULE12: Client leaving returns server to listening
// RULE13: Serial baud selectable from 300 to 115200
// RULE14: Serial port wired as terminal equipment
// RULE15: Client connects to configured port, 1024 to 65535
// RULE16: Power-up starts local with no client
`ifndef RLL_CONSTS_VH
`define RLL_CONSTS_VH

// Remote/local operating states
`define ST_LOCAL          2'h0
`define ST_LOCAL_LOCKOUT  2'h1
`define ST_REMOTE         2'h2
`define ST_REMOTE_LOCKOUT 2'h3

// Network session states
`define NET_IDLE          2'h0
`define NET_LISTEN        2'h1
`define NET_CONNECTED     2'h2

// Socket port defaults and legal range
`define SOCK_PORT_DEFAULT 16'h0DA2
`define SOCK_PORT_MIN     16'h0400

// System clock rate in hertz
`define CLK_HZ            100000000

// Selectable baud rates, index 0 to 9
`define BAUD_0            300
`define BAUD_1            600
`define BAUD_2            1200
`define BAUD_3            2400
`define BAUD_4            4800
`define BAUD_5            9600
`define BAUD_6            19200
`define BAUD_7            38400
`define BAUD_8            57600
`define BAUD_9            115200
`define BAUD_SEL_MAX      4'h9
`define BAUD_CNT_W        19

`endif

// ==== rtl/remote_local_lockout_control.v ====
`timescale 1ns/100ps
`include "rll_consts.vh"

module remote_local_lockout_control #(
  parameter CLK_FREQ_HZ = `CLK_HZ    // Lower in simulation to shorten baud counts
) (
  input  wire        sys_clk_i,        // System clock
  input  wire        reset_i,          // Synchronous reset, active high
  input  wire        cmd_valid_i,      // Remote command received, one-cycle pulse
  input  wire        cmd_remote_i,     // Command is the remote command
  input  wire        cmd_local_i,      // Command is the local command
  input  wire        cmd_lockout_i,    // Command is the lockout command
  input  wire        fp_key_i,         // Ordinary front-panel key, pin level
  input  wire        fp_go_local_i,    // Go-to-local softkey, pin level
  input  wire        fp_power_i,       // Power switch, pin level
  input  wire        sel_lan_i,        // Remote interface selection is network port
  input  wire [15:0] sock_port_i,      // Configured socket port
  input  wire        conn_req_i,       // Client connection attempt, one-cycle pulse
  input  wire        client_close_i,   // Client ended session, one-cycle pulse
  input  wire [3:0]  baud_sel_i,       // Baud rate index
  input  wire        tx_bit_i,         // Serial bit to transmit
  input  wire        rxd_i,            // Serial receive data pin
  output reg  [1:0]  state_o,          // Operating state
  output reg         cmd_exec_o,       // Command passed on for execution
  output reg         fp_key_o,         // Accepted front-panel key press
  output reg         fp_power_o,       // Power switch press, always passed
  output reg         listen_o,         // Server listening
  output reg  [15:0] listen_port_o,    // Port being listened on
  output reg         connected_o,      // One client session active
  output reg         conn_accept_o,    // Connection accepted pulse
  output reg         conn_reject_o,    // Connection refused pulse
  output reg         drop_client_o,    // Device closes client session pulse
  output reg         baud_tick_o,      // One pulse per serial bit time
  output reg         txd_o,            // Serial transmit data pin
  output reg         rx_bit_o          // Synchronised receive data
);

  // Panel pins and receive pin cross into the clock domain
  reg  [3:0] sync1;                   // First synchroniser stage
  reg  [3:0] sync2;                   // Second synchroniser stage
  reg  [2:0] key_prev;                // Previous synchronised key levels
  wire       key_rise;                // Ordinary key pressed
  wire       go_local_rise;           // Go-to-local pressed
  wire       power_rise;              // Power switch pressed

  reg  [1:0] state;                   // Operating state
  reg  [1:0] next_state;              // Next operating state
  reg  [1:0] net_state;               // Network session state
  reg  [1:0] next_net_state;          // Next network session state

  reg  [`BAUD_CNT_W-1:0] baud_cnt;    // Baud divider counter
  reg  [`BAUD_CNT_W-1:0] baud_div;    // Selected divide ratio
  reg  [31:0]            baud_ratio;  // Full-width ratio before trimming to the counter

  // Two flip-flops on every asynchronous pin
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      sync1    <= 4'h0;
      sync2    <= 4'h0;
      key_prev <= 3'h0;
    end else begin
      sync1    <= {rxd_i, fp_power_i, fp_go_local_i, fp_key_i};
      sync2    <= sync1;
      key_prev <= sync2[2:0];
    end
  end

  // Edges taken from the second stage only
  assign key_rise      = sync2[0] & ~key_prev[0];
  assign go_local_rise = sync2[1] & ~key_prev[1];
  assign power_rise    = sync2[2] & ~key_prev[2];

  // Remote/local transitions; lockout beats local beats remote, except in local, where remote beats local
  always @* begin
    next_state = state;
    case (state)
      `ST_LOCAL: begin
        if (cmd_valid_i && cmd_lockout_i) begin
          next_state = `ST_LOCAL_LOCKOUT;              // [RULE2]
        end else if (cmd_valid_i && cmd_remote_i) begin
          next_state = `ST_REMOTE;                     // [RULE3]
        end
      end
      `ST_LOCAL_LOCKOUT: begin
        if (cmd_valid_i && cmd_lockout_i) begin
          next_state = `ST_LOCAL_LOCKOUT;              // [RULE2]
        end else if (cmd_valid_i && cmd_local_i) begin
          next_state = `ST_LOCAL;
        end else if (cmd_valid_i && cmd_remote_i) begin
          next_state = `ST_REMOTE_LOCKOUT;             // [RULE4]
        end
      end
      `ST_REMOTE: begin
        if (cmd_valid_i && cmd_lockout_i) begin
          next_state = `ST_REMOTE_LOCKOUT;             // [RULE2]
        end else if ((cmd_valid_i && cmd_local_i) || go_local_rise) begin
          next_state = `ST_LOCAL;                      // [RULE6]
        end
      end
      `ST_REMOTE_LOCKOUT: begin
        // Go-to-local key has no effect here
        if (cmd_valid_i && cmd_local_i && !cmd_lockout_i) begin
          next_state = `ST_LOCAL_LOCKOUT;              // [RULE8] [RULE7]
        end
      end
      default: begin
        next_state = `ST_LOCAL;
      end
    endcase
  end

  // State register and front-panel gating
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      state      <= `ST_LOCAL;                         // [RULE16]
      state_o    <= `ST_LOCAL;
      cmd_exec_o <= 1'b0;
      fp_key_o   <= 1'b0;
      fp_power_o <= 1'b0;
    end else begin
      state      <= next_state;
      state_o    <= next_state;
      // Every command runs in every state; only the panel is restricted
      cmd_exec_o <= cmd_valid_i;                       // [RULE1]
      // Ordinary keys only count in the two local states
      fp_key_o   <= key_rise && !state[1];             // [RULE1] [RULE5] [RULE7]
      fp_power_o <= power_rise;                        // [RULE5] [RULE7]
    end
  end

  // Single-client session; a request in the same cycle as deselect is refused
  always @* begin
    next_net_state = net_state;
    case (net_state)
      `NET_IDLE: begin
        if (sel_lan_i) begin
          next_net_state = `NET_LISTEN;                // [RULE9]
        end
      end
      `NET_LISTEN: begin
        if (!sel_lan_i) begin
          next_net_state = `NET_IDLE;
        end else if (conn_req_i) begin
          next_net_state = `NET_CONNECTED;
        end
      end
      `NET_CONNECTED: begin
        if (!sel_lan_i) begin
          next_net_state = `NET_IDLE;                  // [RULE11]
        end else if (client_close_i) begin
          next_net_state = `NET_LISTEN;                // [RULE12]
        end
      end
      default: begin
        next_net_state = `NET_IDLE;
      end
    endcase
  end

  // Session register and its pulses
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      net_state     <= `NET_IDLE;                      // [RULE16]
      listen_o      <= 1'b0;
      listen_port_o <= `SOCK_PORT_DEFAULT;
      connected_o   <= 1'b0;
      conn_accept_o <= 1'b0;
      conn_reject_o <= 1'b0;
      drop_client_o <= 1'b0;
    end else begin
      net_state     <= next_net_state;
      listen_o      <= (next_net_state == `NET_LISTEN);
      connected_o   <= (next_net_state == `NET_CONNECTED);
      // Port changes take effect at once; an out-of-range port falls back
      if (sock_port_i < `SOCK_PORT_MIN) begin
        listen_port_o <= `SOCK_PORT_DEFAULT;           // [RULE15]
      end else begin
        listen_port_o <= sock_port_i;                  // [RULE9]
      end
      conn_accept_o <= conn_req_i && (net_state == `NET_LISTEN) && sel_lan_i;
      // Anything not accepted is refused, including a second client
      conn_reject_o <= conn_req_i && !((net_state == `NET_LISTEN) && sel_lan_i); // [RULE10]
      drop_client_o <= (net_state == `NET_CONNECTED) && !sel_lan_i; // [RULE11]
    end
  end

  // Divide ratio per baud index; unknown indexes run at the lowest rate
  always @* begin
    case (baud_sel_i)
      4'h0:    baud_ratio = CLK_FREQ_HZ / `BAUD_0;      // [RULE13]
      4'h1:    baud_ratio = CLK_FREQ_HZ / `BAUD_1;
      4'h2:    baud_ratio = CLK_FREQ_HZ / `BAUD_2;
      4'h3:    baud_ratio = CLK_FREQ_HZ / `BAUD_3;
      4'h4:    baud_ratio = CLK_FREQ_HZ / `BAUD_4;
      4'h5:    baud_ratio = CLK_FREQ_HZ / `BAUD_5;
      4'h6:    baud_ratio = CLK_FREQ_HZ / `BAUD_6;
      4'h7:    baud_ratio = CLK_FREQ_HZ / `BAUD_7;
      4'h8:    baud_ratio = CLK_FREQ_HZ / `BAUD_8;
      4'h9:    baud_ratio = CLK_FREQ_HZ / `BAUD_9;      // [RULE13]
      default: baud_ratio = CLK_FREQ_HZ / `BAUD_0;
    endcase
    // Counter width covers the slowest rate at the default clock
    baud_div = baud_ratio[`BAUD_CNT_W-1:0];
  end

  // Baud enable divider and terminal-side data pins
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      baud_cnt    <= {`BAUD_CNT_W{1'b0}};
      baud_tick_o <= 1'b0;
      txd_o       <= 1'b1;
      rx_bit_o    <= 1'b1;
    end else begin
      // Counter restarts if a new rate leaves it above the ratio
      if (baud_cnt >= baud_div - 1'b1) begin
        baud_cnt    <= {`BAUD_CNT_W{1'b0}};
        baud_tick_o <= 1'b1;                           // [RULE13]
      end else begin
        baud_cnt    <= baud_cnt + 1'b1;
        baud_tick_o <= 1'b0;
      end
      // Terminal equipment drives transmit data and listens on receive
      txd_o    <= tx_bit_i;                            // [RULE14]
      rx_bit_o <= sync2[3];                            // [RULE14]
    end
  end

endmodule // remote_local_lockout_control

// ==== verification/host_model.sv ====
`timescale 1ns/100ps
// Far-side host: issues commands and session events as one-cycle pulses
module host_model (
  input  wire       sys_clk_i,
  input  wire [2:0] go_i,    // Bench request: command, connect, leave
  input  wire [1:0] kind_i,  // 0 remote, 1 local, 2 lockout
  output reg        cmd_valid_o = 1'b0,
  output reg        cmd_remote_o = 1'b0,
  output reg        cmd_local_o = 1'b0,
  output reg        cmd_lockout_o = 1'b0,
  output reg        conn_req_o = 1'b0,
  output reg        client_close_o = 1'b0
);
  // Kind lines toggle while idle so a design must not trust them then
  always @(posedge sys_clk_i) begin
    cmd_valid_o <= go_i[0];
    cmd_remote_o <= go_i[0] ? kind_i == 2'h0 : ~cmd_remote_o;
    cmd_local_o <= go_i[0] ? kind_i == 2'h1 : ~cmd_local_o;
    cmd_lockout_o <= go_i[0] ? kind_i == 2'h2 : ~cmd_lockout_o;
    conn_req_o <= go_i[1];     // Only aimed at the configured port
    client_close_o <= go_i[2];
  end
endmodule // host_model

// ==== verification/remote_local_lockout_control_tb.sv ====
`timescale 1ns/100ps
module remote_local_lockout_control_tb;
  reg        clk = 0, rst = 1, sel = 0, txb = 1, rxd = 1;
  reg [2:0]  fp = 3'h0, go = 3'h0; // Panel pins {power, go-local, key}
  reg [1:0]  kind = 2'h0, st;
  reg [3:0]  bsel = 4'h9;
  reg [15:0] port = 16'h0DA2;
  wire       cv, cr, cl, ck, cq, cc, ex, ko, po, li, co, ac, rj, dr, bt, tx, rx;
  wire [1:0] so;
  wire [15:0] lp;
  int fail_count = 0, checks_done = 0, cyc = 0, n;
  integer    kc, pc; // Four-state so an unknown pulse is not counted as zero
  host_model host (.sys_clk_i(clk), .go_i(go), .kind_i(kind), .cmd_valid_o(cv),
    .cmd_remote_o(cr), .cmd_local_o(cl), .cmd_lockout_o(ck), .conn_req_o(cq),
    .client_close_o(cc));
  // Scaled clock rate keeps bit times short: 115200 gives 10, 300 gives 3840
  remote_local_lockout_control #(.CLK_FREQ_HZ(1152000)) DUT (.sys_clk_i(clk), .reset_i(rst),
    .cmd_valid_i(cv), .cmd_remote_i(cr), .cmd_local_i(cl), .cmd_lockout_i(ck),
    .fp_key_i(fp[0]), .fp_go_local_i(fp[1]), .fp_power_i(fp[2]), .sel_lan_i(sel),
    .sock_port_i(port), .conn_req_i(cq), .client_close_i(cc), .baud_sel_i(bsel),
    .tx_bit_i(txb), .rxd_i(rxd), .state_o(so), .cmd_exec_o(ex), .fp_key_o(ko),
    .fp_power_o(po), .listen_o(li), .listen_port_o(lp), .connected_o(co),
    .conn_accept_o(ac), .conn_reject_o(rj), .drop_client_o(dr), .baud_tick_o(bt),
    .txd_o(tx), .rx_bit_o(rx));
  initial forever #5 clk = ~clk;
  // Watchdog: a hang counts as a mismatch
  always @(posedge clk) if (++cyc == 30000) begin
    fail_count++;
    summarize();
  end
  task summarize;
    if (fail_count == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input [15:0] got, input [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Expected state after one command
  function [1:0] nxt(input [1:0] s, input [1:0] k);
    case (k)
      2'h2: nxt = s[1] ? 2'h3 : 2'h1;
      2'h1: nxt = (s == 2'h3) ? 2'h1 : 2'h0;
      default: nxt = s[0] ? 2'h3 : 2'h2;
    endcase
  endfunction
  // One host event; returns just after the edge where the design answers
  task op(input [2:0] g, input [1:0] k);
    @(posedge clk) begin go <= g; kind <= k; end
    @(posedge clk) go <= 3'h0;
    @(posedge clk) #1;
  endtask
  // Hold a panel pin 6 cycles, release 6, counting pulses
  task press(input [2:0] m);
    kc = 0; pc = 0;
    @(posedge clk) fp <= m;
    for (int i = 0; i < 12; i++) @(posedge clk) begin
      kc += ko; pc += po;
      if (i == 5) fp <= 3'h0;
    end
    #1;
  endtask
  // Cycles between two bit-time ticks
  task gap(input [3:0] b, input int d);
    int c;
    @(posedge clk) bsel <= b;
    repeat (3) begin
      c = 0;
      do begin @(posedge clk); c++; end while (bt !== 1'b1 && c < 5000);
    end
    chk(c, d);
  endtask
  initial begin
    n = $urandom(32'hA751);
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk) #1;
    chk(so, 2'h0); chk(co, 1'h0); chk(li, 1'h0); chk(tx, 1'h1);
    st = 2'h0;
    for (int i = 0; i < 60; i++) begin
      n = $urandom_range(2);
      op(3'h1, n[1:0]);
      st = nxt(st, n[1:0]);
      chk(so, st); chk(ex, 1'h1);
    end
    // Each state reached fresh from a second reset, then every panel pin
    for (int s = 0; s < 4; s++) begin
      @(posedge clk) rst <= 1'b1;
      @(posedge clk) rst <= 1'b0;
      if (s[0]) op(3'h1, 2'h2);
      if (s[1]) op(3'h1, 2'h0);
      press(3'h1); chk(kc, s < 2);
      press(3'h4); chk(pc, 1'h1);
      press(3'h2); chk(so, s == 2 ? 2'h0 : s[1:0]);
    end
    @(posedge clk) begin port <= 16'h0400 + 16'($urandom_range(64511)); sel <= 1'b1; end
    repeat (2) @(posedge clk);
    #1 chk(li, 1'h1); chk(lp, port);
    op(3'h2, 2'h0); chk(ac, 1'h1); chk(co, 1'h1);
    op(3'h2, 2'h0); chk(rj, 1'h1); chk(ac, 1'h0);
    op(3'h4, 2'h0); chk(li, 1'h1); chk(co, 1'h0);
    op(3'h2, 2'h0); chk(co, 1'h1);
    @(posedge clk) sel <= 1'b0;
    @(posedge clk) #1 chk(dr, 1'h1); chk(co, 1'h0);
    @(posedge clk) port <= 16'($urandom_range(1023));
    @(posedge clk) #1 chk(lp, 16'h0DA2);
    for (int i = 0; i < 8; i++) begin
      n = $urandom;
      @(posedge clk) begin txb <= n[0]; rxd <= n[1]; end
      @(posedge clk) #1 chk(tx, n[0]);
      repeat (2) @(posedge clk);
      #1 chk(rx, n[1]);
    end
    gap(4'h9, 10);
    gap(4'h0, 3840);
    gap(4'h5, 120);
    summarize();
  end
endmodule // remote_local_lockout_control_tb

// ==== verification/rll_properties.sv ====
`timescale 1ns/100ps
// Watches the top ports; only the remote check uses single-kind commands, the local and lockout checks rely on priority
module rll_properties (
  input wire       sys_clk_i, reset_i, cmd_valid_i, cmd_remote_i, cmd_local_i,
  input wire       cmd_lockout_i, sel_lan_i, conn_req_i, client_close_i, cmd_exec_o,
  input wire       fp_key_o, listen_o, connected_o, conn_accept_o, conn_reject_o,
  input wire       drop_client_o,
  input wire [1:0] state_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  wire rem = cmd_valid_i & cmd_remote_i & ~cmd_local_i & ~cmd_lockout_i; // Remote only
  wire loc = cmd_valid_i & cmd_local_i & ~cmd_lockout_i; // Local, lockout absent
  wire lck = cmd_valid_i & cmd_lockout_i;                // Lockout wins
  sequence s_dropped;
    drop_client_o && !connected_o && !listen_o;
  endsequence
  a_cmd_executed: assert property (cmd_valid_i |=> cmd_exec_o)
    else $error("command not executed");
  a_exec_follows_cmd: assert property (cmd_exec_o |-> $past(cmd_valid_i))
    else $error("execute pulse without command");
  a_lockout_entry: assert property (lck && !state_o[1] |=> state_o == 2'h1)
    else $error("lockout not entered");
  a_remote_entry: assert property (rem && state_o == 2'h0 |=> state_o == 2'h2)
    else $error("remote not entered");
  a_locked_remote: assert property (rem && state_o == 2'h1 |=> state_o == 2'h3)
    else $error("locked remote not entered");
  a_key_gated: assert property (fp_key_o |-> !$past(state_o[1]))
    else $error("panel key passed in remote");
  a_remote_release: assert property (loc && state_o == 2'h2 |=> state_o == 2'h0)
    else $error("remote not released");
  a_locked_release: assert property (loc && state_o == 2'h3 |=> state_o == 2'h1)
    else $error("locked remote not released");
  a_listen_start: assert property ($rose(sel_lan_i) && !connected_o |=> listen_o)
    else $error("server not listening");
  a_single_client: assert property (connected_o && conn_req_i |=> conn_reject_o)
    else $error("extra client not refused");
  a_drop_deselect: assert property (connected_o && !sel_lan_i |=> s_dropped)
    else $error("client not dropped");
  a_listen_again: assert property (connected_o && sel_lan_i && client_close_i
    |=> listen_o && !connected_o)
    else $error("server not listening again");
endmodule // rll_properties
bind remote_local_lockout_control rll_properties chk (.*);
